// >>> design/pgen_defs.vh
// Purpose: Shared constants for the pattern generator output control.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:   Definitions only; no logic lives here.
`ifndef PGEN_DEFS_VH
`define PGEN_DEFS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_OUT_CTRL  8'h00
`define OFS_ERR_CFG   8'h04
`define OFS_DATA_AMP  8'h08
`define OFS_DATA_OFS  8'h0C
`define OFS_DATA_XPT  8'h10
`define OFS_STATUS    8'h14

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CTL_OUT_ON    0
`define CTL_ERR_EN    1
`define CTL_POL_NEG   2
`define CTL_OPTIC     3
`define CTL_SRC_LO    4
`define CTL_SRC_HI    5
`define CTL_DIV64     6
`define ECF_SINGLE    0
`define ECF_RATE_LO   4
`define ECF_RATE_HI   7

// ------------------------------------------------------------
// Clock source codes
// ------------------------------------------------------------
`define SRC_INTERNAL  2'h0
`define SRC_REF       2'h1
`define SRC_EXT       2'h2

// ------------------------------------------------------------
// Reset values and legal ranges (codes in 0.01 units)
// ------------------------------------------------------------
`define AMP_RESET     8'h64
`define AMP_MIN       8'h32
`define AMP_MAX       8'hC8
`define OFS_RESET     10'h000
`define OFS_MIN       10'h338
`define OFS_MAX       10'h12C
`define XPT_RESET     7'h32
`define XPT_MIN       7'h1E
`define XPT_MAX       7'h46
`define RATE_MAX      4'h9

// ------------------------------------------------------------
// Error period in 8-bit words, 1.0E-3 down to 1.0E-12
// ------------------------------------------------------------
`define PER_E3        40'h00_0000_007D
`define PER_E4        40'h00_0000_04E2
`define PER_E5        40'h00_0000_30D4
`define PER_E6        40'h00_0001_E848
`define PER_E7        40'h00_0013_12D0
`define PER_E8        40'h00_00BE_BC20
`define PER_E9        40'h00_0773_5940
`define PER_E10       40'h00_4A81_7C80
`define PER_E11       40'h02_E90E_DD00
`define PER_E12       40'h1D_1A94_A200

`endif

// >>> design/stream_fifo.v
// Purpose: Small word FIFO with valid/ready on both sides.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Read data come from a register stage after the memory.
`timescale 1ns/1ps
module stream_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_i,              // system clock
  input wire rst_i,              // synchronous reset
  input wire in_valid_i,         // write word offered
  input wire [WIDTH-1:0] in_data_i, // write word
  output wire in_ready_o,        // memory not full
  output wire out_valid_o,       // read word held
  output wire [WIDTH-1:0] out_data_o, // read word, registered
  input wire out_ready_i         // reader takes the word
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  reg out_valid_q;
  reg [WIDTH-1:0] out_data_q;
  wire full;
  wire push;
  wire pop;

  assign full = (count_q == DEPTH[AW:0]);
  assign in_ready_o = !full;
  assign push = in_valid_i && !full;
  // Refill the output register whenever it is free or being taken.
  assign pop = (count_q != {(AW+1){1'b0}}) &&
               (!out_valid_q || out_ready_i);
  assign out_valid_o = out_valid_q;
  assign out_data_o = out_data_q;

  always @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      out_valid_q <= 1'b0;
      out_data_q <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
        out_data_q <= mem_q[rd_ptr_q];
        out_valid_q <= 1'b1;
      end else if (out_ready_i) begin
        out_valid_q <= 1'b0;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // stream_fifo

// >>> design/pattern_gen_output_error_ctl.v
// Purpose: Output switching, error insertion, clock source and path
//          selection for the pattern generator transmit side.
// Assumes: APB slave on clk_i, zero wait states; 8-bit words per beat.
// Notes:   Bit 0 of a word is the bit that carries an inserted error.
`timescale 1ns/1ps
`include "pgen_defs.vh"
module pattern_gen_output_error_ctl (
  input wire clk_i,              // 20 MHz system clock
  input wire rst_i,              // synchronous reset, active high
  input wire psel_i,             // APB select
  input wire penable_i,          // APB access phase
  input wire pwrite_i,           // APB write
  input wire [7:0] paddr_i,      // APB byte address
  input wire [31:0] pwdata_i,    // APB write data
  output wire [31:0] prdata_o,   // APB read data
  output wire pready_o,          // APB ready, always high
  output wire pslverr_o,         // APB error on unmapped address
  input wire pat_valid_i,        // pattern word offered
  input wire [7:0] pat_data_i,   // pattern word
  output wire pat_ready_o,       // FIFO can take a word
  output wire line_valid_o,      // output word valid
  input wire line_ready_i,       // serializer takes output word
  output wire [7:0] data_true_o, // non-invert data output
  output wire [7:0] data_comp_o, // invert data output
  output wire [7:0] mod_data_o,  // data for optical modulator
  output wire clk_true_o,        // non-invert clock output
  output wire clk_comp_o,        // invert clock output
  output wire [1:0] clk_src_o,   // selected bit clock source
  output wire ref_div64_o,       // reference ratio, 1 = 1/64
  output wire path_optic_o,      // optical output path selected
  output wire [7:0] amp_code_o,  // data amplitude code
  output wire [9:0] ofs_code_o,  // data offset code, signed
  output wire [6:0] xpt_code_o   // data cross point code
);

  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  reg out_on_q;
  reg err_en_q;
  reg pol_neg_q;
  reg optic_q;
  reg [1:0] src_q;
  reg div64_q;
  reg single_q;
  reg [3:0] rate_q;
  reg [7:0] amp_q;
  reg [9:0] ofs_q;
  reg [6:0] xpt_q;
  reg [31:0] prdata_q;
  reg [39:0] rate_cnt_q;
  reg [15:0] inj_cnt_q;
  reg line_valid_q;
  reg [7:0] word_q;
  reg [7:0] data_true_q;
  reg [7:0] data_comp_q;
  reg [7:0] mod_data_q;
  reg clk_tog_q;
  reg clk_true_q;
  reg clk_comp_q;
  reg [39:0] period;
  reg [31:0] rd_mux;
  reg addr_ok;
  wire fifo_valid;
  wire [7:0] fifo_data;
  wire fifo_ready;
  wire take;
  wire rate_hit;
  wire inject;
  wire wr_en;
  wire setup;
  wire [7:0] err_mask;
  wire [7:0] fresh;
  wire [7:0] word_d;
  wire [1:0] src_w;
  wire [3:0] rate_w;
  wire [9:0] ofs_w;

  // ----------------------------------------------------------
  // Pattern FIFO
  // ----------------------------------------------------------
  stream_fifo #(
    .WIDTH(8),
    .DEPTH(8),
    .AW(3)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(pat_valid_i),
    .in_data_i(pat_data_i),
    .in_ready_o(pat_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(fifo_ready)
  );

  // ----------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------
  assign setup = psel_i && !penable_i;
  assign wr_en = psel_i && penable_i && pwrite_i && addr_ok;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !addr_ok;
  assign prdata_o = prdata_q;
  assign src_w = pwdata_i[`CTL_SRC_HI:`CTL_SRC_LO];
  assign rate_w = pwdata_i[`ECF_RATE_HI:`ECF_RATE_LO];
  assign ofs_w = pwdata_i[9:0];

  always @* begin
    addr_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr_i)
      `OFS_OUT_CTRL: begin
        rd_mux[`CTL_OUT_ON] = out_on_q;
        rd_mux[`CTL_ERR_EN] = err_en_q;
        rd_mux[`CTL_POL_NEG] = pol_neg_q;
        rd_mux[`CTL_OPTIC] = optic_q;
        rd_mux[`CTL_SRC_HI:`CTL_SRC_LO] = src_q;
        rd_mux[`CTL_DIV64] = div64_q;
      end
      `OFS_ERR_CFG: begin
        rd_mux[`ECF_SINGLE] = single_q;
        rd_mux[`ECF_RATE_HI:`ECF_RATE_LO] = rate_q;
      end
      `OFS_DATA_AMP: rd_mux[7:0] = amp_q;
      `OFS_DATA_OFS: rd_mux[9:0] = ofs_q;
      `OFS_DATA_XPT: rd_mux[6:0] = xpt_q;
      `OFS_STATUS: begin
        rd_mux[0] = err_en_q;
        rd_mux[1] = line_valid_q;
        rd_mux[2] = !pat_ready_o;
        rd_mux[3] = fifo_valid;
        rd_mux[31:16] = inj_cnt_q;
      end
      default: addr_ok = 1'b0;
    endcase
  end

  // Read data are caught in the setup cycle so that a zero-wait
  // access phase still presents them from a flip-flop.
  always @(posedge clk_i) begin
    if (rst_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= rd_mux;
    end
  end

  // ----------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      out_on_q <= 1'b0;
      err_en_q <= 1'b0;
      pol_neg_q <= 1'b0;
      optic_q <= 1'b0;
      src_q <= `SRC_INTERNAL;
      div64_q <= 1'b0;
      single_q <= 1'b1;
      rate_q <= 4'h0;
    end else begin
      if (wr_en && paddr_i == `OFS_OUT_CTRL) begin
        out_on_q <= pwdata_i[`CTL_OUT_ON];
        // A software write wins over the self-clear in the same cycle.
        err_en_q <= pwdata_i[`CTL_ERR_EN];
        pol_neg_q <= pwdata_i[`CTL_POL_NEG];
        optic_q <= pwdata_i[`CTL_OPTIC];
        if (src_w != 2'h3) begin
          src_q <= src_w;
        end
        if (src_w == `SRC_REF) begin
          div64_q <= pwdata_i[`CTL_DIV64];
        end
      end else if (inject && single_q) begin
        err_en_q <= 1'b0;
      end
      if (wr_en && paddr_i == `OFS_ERR_CFG) begin
        single_q <= pwdata_i[`ECF_SINGLE];
        if (rate_w <= `RATE_MAX) begin
          rate_q <= rate_w;
        end
      end
    end
  end

  // ----------------------------------------------------------
  // Analog setting codes
  // ----------------------------------------------------------
  // Out-of-range codes are dropped rather than clamped, so the
  // previous legal setting stays in force.
  always @(posedge clk_i) begin
    if (rst_i) begin
      amp_q <= `AMP_RESET;
      ofs_q <= `OFS_RESET;
      xpt_q <= `XPT_RESET;
    end else if (wr_en && !optic_q) begin
      if (paddr_i == `OFS_DATA_AMP && pwdata_i[7:0] >= `AMP_MIN &&
          pwdata_i[7:0] <= `AMP_MAX) begin
        amp_q <= pwdata_i[7:0];
      end
      if (paddr_i == `OFS_DATA_OFS &&
          $signed(ofs_w) >= $signed(`OFS_MIN) &&
          $signed(ofs_w) <= $signed(`OFS_MAX)) begin
        ofs_q <= ofs_w;
      end
      if (paddr_i == `OFS_DATA_XPT && pwdata_i[6:0] >= `XPT_MIN &&
          pwdata_i[6:0] <= `XPT_MAX) begin
        xpt_q <= pwdata_i[6:0];
      end
    end
  end

  // One code serves both data outputs of the pair.
  assign amp_code_o = amp_q;
  assign ofs_code_o = ofs_q;
  assign xpt_code_o = xpt_q;
  assign clk_src_o = src_q;
  assign ref_div64_o = div64_q;
  assign path_optic_o = optic_q;

  // ----------------------------------------------------------
  // Error insertion
  // ----------------------------------------------------------
  always @* begin
    case (rate_q)
      4'h0: period = `PER_E3;
      4'h1: period = `PER_E4;
      4'h2: period = `PER_E5;
      4'h3: period = `PER_E6;
      4'h4: period = `PER_E7;
      4'h5: period = `PER_E8;
      4'h6: period = `PER_E9;
      4'h7: period = `PER_E10;
      4'h8: period = `PER_E11;
      default: period = `PER_E12;
    endcase
  end

  assign fifo_ready = !line_valid_q || line_ready_i;
  assign take = fifo_valid && fifo_ready;
  assign rate_hit = (rate_cnt_q == period - 40'h00_0000_0001);
  assign inject = take && err_en_q && (single_q || rate_hit);

  // Rate counter counts words; each word is 8 bits, so the period
  // table already holds bit spacing divided by 8.
  always @(posedge clk_i) begin
    if (rst_i) begin
      rate_cnt_q <= 40'h00_0000_0000;
      inj_cnt_q <= 16'h0000;
    end else begin
      if (!err_en_q || single_q) begin
        rate_cnt_q <= 40'h00_0000_0000;
      end else if (take) begin
        if (rate_hit) begin
          rate_cnt_q <= 40'h00_0000_0000;
        end else begin
          rate_cnt_q <= rate_cnt_q + 40'h00_0000_0001;
        end
      end
      if (inject) begin
        inj_cnt_q <= inj_cnt_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------
  // Polarity and error per bit
  // ----------------------------------------------------------
  assign err_mask = inject ? 8'h01 : 8'h00;

  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_bit
      // The flip follows polarity so only the chosen bit changes.
      assign fresh[b] = fifo_data[b] ^ pol_neg_q ^ err_mask[b];
    end
  endgenerate

  assign word_d = take ? fresh : word_q;

  // ----------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------
  // Every data and clock output pin is loaded from the same switch on the same
  // edge, so an on/off change can never skew data against clock.
  always @(posedge clk_i) begin
    if (rst_i) begin
      line_valid_q <= 1'b0;
      word_q <= 8'h00;
      data_true_q <= 8'h00;
      data_comp_q <= 8'h00;
      mod_data_q <= 8'h00;
      clk_tog_q <= 1'b0;
      clk_true_q <= 1'b0;
      clk_comp_q <= 1'b0;
    end else begin
      if (take) begin
        line_valid_q <= 1'b1;
      end else if (line_ready_i) begin
        line_valid_q <= 1'b0;
      end
      word_q <= word_d;
      clk_tog_q <= !clk_tog_q;
      if (out_on_q) begin
        clk_true_q <= clk_tog_q;
        clk_comp_q <= !clk_tog_q;
        mod_data_q <= word_d;
        if (optic_q) begin
          data_true_q <= 8'h00;
          data_comp_q <= 8'h00;
        end else begin
          data_true_q <= word_d;
          data_comp_q <= ~word_d;
        end
      end else begin
        clk_true_q <= 1'b0;
        clk_comp_q <= 1'b0;
        mod_data_q <= 8'h00;
        data_true_q <= 8'h00;
        data_comp_q <= 8'h00;
      end
    end
  end

  assign line_valid_o = line_valid_q;
  assign data_true_o = data_true_q;
  assign data_comp_o = data_comp_q;
  assign mod_data_o = mod_data_q;
  assign clk_true_o = clk_true_q;
  assign clk_comp_o = clk_comp_q;

endmodule // pattern_gen_output_error_ctl

// >>> test/line_sink.sv
// Purpose: Receiver model taking words from the output stage.
// Assumes: stall_i changes right after a rising clock edge.
// Notes:   Keeps true, complement and modulator data per word.
`timescale 1ns/1ps
module line_sink (
  input logic clk_i,        // clock
  input logic rst_i,        // reset
  input logic stall_i,      // hold off
  input logic line_valid_i, // word offered
  input logic [7:0] t_i,    // true data
  input logic [7:0] c_i,    // complement data
  input logic [7:0] m_i,    // modulator data
  output logic line_ready_o // word taken
);
  // ----------------------------------------------------------
  // Capture
  // ----------------------------------------------------------
  logic [23:0] q [$];
  // Ready follows the stall alone, so the bench can fill the buffer.
  assign line_ready_o = !stall_i;
  always @(posedge clk_i) begin
    if (rst_i)
      q.delete();
    else if (line_valid_i && line_ready_o)
      q.push_back({t_i, c_i, m_i});
  end
endmodule // line_sink

// >>> test/pgen_out_chk.sv
// Purpose: Port checks for the output control block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound into every instance of the block.
`timescale 1ns/1ps
`include "pgen_defs.vh"
module pgen_out_chk (
  input logic clk_i,            // clock
  input logic rst_i,            // reset
  input logic psel_i,           // select
  input logic penable_i,        // access
  input logic pwrite_i,         // write
  input logic [7:0] paddr_i,    // address
  input logic [31:0] pwdata_i,  // write data
  input logic pready_o,         // ready
  input logic pslverr_o,        // error
  input logic line_valid_o,     // word valid
  input logic line_ready_i,     // word taken
  input logic [7:0] data_true_o, // true data
  input logic [7:0] data_comp_o, // complement data
  input logic [7:0] mod_data_o, // modulator data
  input logic clk_true_o,       // true clock
  input logic clk_comp_o,       // complement clock
  input logic [1:0] clk_src_o,  // clock source
  input logic ref_div64_o,      // reference ratio
  input logic path_optic_o,     // optical path
  input logic [7:0] amp_code_o  // amplitude
);
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic bad_addr;
  assign bad_addr = (paddr_i[1:0] != 2'b00) || (paddr_i > `OFS_STATUS);
  sequence off_wr;
    psel_i && penable_i && pwrite_i && paddr_i == `OFS_OUT_CTRL
      && !pwdata_i[0];
  endsequence
  sequence all_quiet;
    data_true_o == 8'h00 && data_comp_o == 8'h00 && mod_data_o == 8'h00
      && !clk_true_o && !clk_comp_o;
  endsequence
  chk_off_quiet: assert property (off_wr |-> ##2 all_quiet)
    else $error("outputs still active after switch off");
  chk_pair_inverse: assert property (
    (data_true_o != 8'h00 || data_comp_o != 8'h00)
      |-> data_comp_o == ~data_true_o)
    else $error("data pair not complementary");
  chk_clk_toggle: assert property (
    clk_true_o |-> !clk_comp_o ##1 !clk_true_o)
    else $error("clock pair wrong");
  chk_optic_silent: assert property (
    path_optic_o && $past(path_optic_o)
      |-> data_true_o == 8'h00 && data_comp_o == 8'h00)
    else $error("data pair driven on optical path");
  chk_amp_locked: assert property (
    $past(path_optic_o) |-> $stable(amp_code_o))
    else $error("amplitude changed on optical path");
  chk_amp_range: assert property (
    amp_code_o >= `AMP_MIN && amp_code_o <= `AMP_MAX)
    else $error("amplitude code out of range");
  chk_div_locked: assert property (
    $changed(ref_div64_o) |-> clk_src_o == `SRC_REF)
    else $error("ratio changed off reference source");
  chk_src_legal: assert property (clk_src_o != 2'h3)
    else $error("illegal clock source");
  chk_apb_answer: assert property (
    psel_i && penable_i |-> pready_o && pslverr_o == bad_addr)
    else $error("bus answer wrong");
  chk_line_hold: assert property (
    line_valid_o && !line_ready_i |=> line_valid_o)
    else $error("word dropped while stalled");
endmodule // pgen_out_chk

bind pattern_gen_output_error_ctl pgen_out_chk u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o),
  .line_valid_o(line_valid_o), .line_ready_i(line_ready_i),
  .data_true_o(data_true_o), .data_comp_o(data_comp_o),
  .mod_data_o(mod_data_o), .clk_true_o(clk_true_o),
  .clk_comp_o(clk_comp_o), .clk_src_o(clk_src_o),
  .ref_div64_o(ref_div64_o), .path_optic_o(path_optic_o),
  .amp_code_o(amp_code_o));

// >>> test/pattern_gen_output_error_ctl_test.sv
// Purpose: Self-checking bench for the output control block.
// Assumes: 50 ns clock, APB master tasks, line_sink on the output.
// Notes:   One idle cycle separates bus transfers.
`timescale 1ns/1ps
`include "pgen_defs.vh"
module pattern_gen_output_error_ctl_test;
  // ----------------------------------------------------------
  // Signals and tasks
  // ----------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, err;
  logic pat_valid_i = 1'b0, stall = 1'b0, line_ready_i, a;
  logic [7:0] paddr_i = 8'h00, pat_data_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000, rdat;
  logic [23:0] got;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, pat_ready_o, line_valid_o;
  wire clk_true_o, clk_comp_o, ref_div64_o, path_optic_o;
  wire [7:0] data_true_o, data_comp_o, mod_data_o, amp_code_o;
  wire [1:0] clk_src_o;
  wire [9:0] ofs_code_o;
  wire [6:0] xpt_code_o;
  integer n_fail = 0, n_checks = 0, i, n, s;
  logic [7:0] src_w [4] = '{8'h61, 8'h51, 8'h31, 8'h01};
  logic [2:0] src_e [4] = '{3'b100, 3'b011, 3'b011, 3'b001};
  logic [7:0] path_w [3] = '{8'h01, 8'h05, 8'h09};
  logic [15:0] path_e [3] = '{16'hA55A, 16'h5AA5, 16'h0000};

  pattern_gen_output_error_ctl DUT (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .pat_valid_i(pat_valid_i), .pat_data_i(pat_data_i),
    .pat_ready_o(pat_ready_o), .line_valid_o(line_valid_o),
    .line_ready_i(line_ready_i), .data_true_o(data_true_o),
    .data_comp_o(data_comp_o), .mod_data_o(mod_data_o),
    .clk_true_o(clk_true_o), .clk_comp_o(clk_comp_o),
    .clk_src_o(clk_src_o), .ref_div64_o(ref_div64_o),
    .path_optic_o(path_optic_o), .amp_code_o(amp_code_o),
    .ofs_code_o(ofs_code_o), .xpt_code_o(xpt_code_o));
  line_sink u_sink (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
    .line_valid_i(line_valid_o), .t_i(data_true_o), .c_i(data_comp_o),
    .m_i(mod_data_o), .line_ready_o(line_ready_i));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  task chk(input [31:0] g, input [31:0] e, input string w);
    n_checks = n_checks + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t: %s got %h want %h", $time, w, g, e);
    end
  endtask

  // A transfer starts one edge after entry, so releases never collide.
  task apb(input logic we, input [7:0] ad, input [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= we;
    paddr_i <= ad;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // The wait has no limit of its own, so a hang is ended and counted by the watchdog.
    do
      @(posedge clk_i);
    while (pready_o !== 1'b1);
    rdat = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task wr(input [7:0] ad, input [31:0] d);
    apb(1'b1, ad, d);
  endtask

  task rdchk(input [7:0] ad, input [31:0] e, input string w);
    apb(1'b0, ad, 32'h0000_0000);
    chk(rdat, e, w);
  endtask

  task push(input [7:0] d);
    @(posedge clk_i);
    pat_valid_i <= 1'b1;
    pat_data_i <= d;
    do
      @(posedge clk_i);
    while (pat_ready_o !== 1'b1);
    pat_valid_i <= 1'b0;
  endtask

  task take(input integer c);
    integer k;
    k = 0;
    while (u_sink.q.size() < c && k < 2000) begin
      @(posedge clk_i);
      k = k + 1;
    end
    chk(u_sink.q.size(), c, "words out");
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task t_regs;
    rdchk(`OFS_DATA_AMP, 32'h0000_0064, "amp reset");
    rdchk(`OFS_OUT_CTRL, 32'h0000_0000, "ctrl reset");
    wr(8'h18, 32'h0000_00FF);
    chk(err, 1, "unmapped");
    wr(`OFS_OUT_CTRL, 32'h0000_0008);
    wr(`OFS_DATA_AMP, 32'h0000_0080);
    rdchk(`OFS_DATA_AMP, 32'h0000_0064, "amp optic");
    chk(path_optic_o, 1, "optic port");
    wr(`OFS_DATA_OFS, 32'h0000_0010);
    rdchk(`OFS_DATA_OFS, 32'h0000_0000, "ofs optic");
    wr(`OFS_OUT_CTRL, 32'h0000_0000);
    wr(`OFS_DATA_AMP, 32'h0000_00C9);
    rdchk(`OFS_DATA_AMP, 32'h0000_0064, "amp range");
    wr(`OFS_DATA_XPT, 32'h0000_0046);
    wr(`OFS_DATA_AMP, 32'h0000_00C8);
    rdchk(`OFS_DATA_AMP, 32'h0000_00C8, "amp top");
    chk(amp_code_o, 32'h0000_00C8, "amp port");
    chk({ofs_code_o, xpt_code_o}, 32'h0000_0046, "ofs xpt port");
    $display("test regs done");
  endtask

  task t_clk;
    for (i = 0; i < 4; i++) begin
      wr(`OFS_OUT_CTRL, {24'h00_0000, src_w[i]});
      repeat (2) @(posedge clk_i);
      chk({clk_src_o, ref_div64_o}, src_e[i], "clock select");
    end
    a = clk_true_o;
    @(posedge clk_i);
    chk({clk_true_o, clk_comp_o}, {!a, a}, "clock pair");
    $display("test clock done");
  endtask

  task t_path;
    for (i = 0; i < 3; i++) begin
      wr(`OFS_OUT_CTRL, {24'h00_0000, path_w[i]});
      u_sink.q.delete();
      push(8'hA5);
      take(1);
      got = u_sink.q.pop_front();
      chk(got[23:8], path_e[i], "pair");
      chk(got[7:0], (i == 1) ? 8'h5A : 8'hA5, "modulator");
    end
    wr(`OFS_OUT_CTRL, 32'h0000_0000);
    repeat (3) @(posedge clk_i);
    chk({data_true_o, data_comp_o, mod_data_o, clk_true_o, clk_comp_o},
      0, "off");
    $display("test path done");
  endtask

  task t_err;
    wr(`OFS_ERR_CFG, 32'h0000_0001);
    wr(`OFS_OUT_CTRL, 32'h0000_0003);
    u_sink.q.delete();
    for (i = 0; i < 3; i++)
      push(8'h00);
    take(3);
    for (i = 0; i < 3; i++) begin
      got = u_sink.q.pop_front();
      chk(got[23:8], (i == 0) ? 16'h01FE : 16'h00FF, "single");
    end
    // The 1/64 ratio chosen in the clock test is still stored in bit 6.
    rdchk(`OFS_OUT_CTRL, 32'h0000_0041, "self clear");
    apb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk(rdat[31:16], 1, "error count");
    $display("test single done");
  endtask

  task t_rate;
    wr(`OFS_ERR_CFG, 32'h0000_0000);
    wr(`OFS_OUT_CTRL, 32'h0000_0003);
    u_sink.q.delete();
    for (i = 0; i < 250; i++)
      push(8'h00);
    take(250);
    wr(`OFS_OUT_CTRL, 32'h0000_0001);
    n = 0;
    s = 0;
    for (i = 0; i < 250; i++) begin
      got = u_sink.q.pop_front();
      if (got[23:16] !== 8'h00) begin
        n = n + 1;
        s = s + i;
      end
    end
    chk(n, 2, "rate count");
    chk(s, 373, "rate place");
    wr(`OFS_ERR_CFG, 32'h0000_0090);
    wr(`OFS_ERR_CFG, 32'h0000_00A0);
    rdchk(`OFS_ERR_CFG, 32'h0000_0090, "rate code");
    $display("test rate done");
  endtask

  task t_fifo;
    u_sink.q.delete();
    stall <= 1'b1;
    n = 0;
    @(posedge clk_i);
    pat_valid_i <= 1'b1;
    pat_data_i <= 8'h10;
    while (n < 30) begin
      @(posedge clk_i);
      if (pat_ready_o !== 1'b1)
        break;
      n = n + 1;
      pat_data_i <= 8'h10 + n[7:0];
    end
    pat_valid_i <= 1'b0;
    // Eight words in memory, one in the read register, one in the stage.
    chk(n, 10, "fifo full");
    stall <= 1'b0;
    take(n);
    for (i = 0; i < n; i++) begin
      got = u_sink.q.pop_front();
      chk(got[23:16], 8'h10 + i[7:0], "fifo order");
    end
    $display("test fifo done");
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_clk;
    t_path;
    t_err;
    t_rate;
    t_fifo;
    end_of_test;
  end

  initial begin
    #(20000 * 50);
    n_fail = n_fail + 1;
    $display("unexpected at %0t: watchdog expired", $time);
    end_of_test;
  end
endmodule // pattern_gen_output_error_ctl_test
